// file: lpteb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module lpteb_host_model
  import lpteb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [15:0] tbl_rd_data,
  input wire logic tbl_rd_valid,
  output logic param_valid,
  output lpteb_param_type param_word,
  output logic recfg_valid,
  output lpteb_recfg_type recfg,
  output logic tbl_rd_en,
  output lpteb_row_type tbl_rd_addr
);
  initial begin
    {param_valid, recfg_valid, tbl_rd_en} = 3'h0;
    {param_word, recfg, tbl_rd_addr} = '0;
  end
  // One word per byte, type and position beside it
  task automatic put(input logic [7:0] t, input logic [7:0] a,
                     input logic [7:0] v);
    @(posedge clk_sys);
    #1;
    param_word = '{t, a, v};
    param_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    param_valid = 1'b0;
    param_word = ~param_word; // Stale word must never look current
  endtask
  task automatic cfg(input logic [3:0] l, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    recfg = '{l, d};
    recfg_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    recfg_valid = 1'b0;
    recfg = ~recfg;
  endtask
  // Row is position halved; halves above 63 fall in bank 7
  task automatic get(input logic [7:0] pos, output logic [7:0] b,
                     output logic vld);
    @(posedge clk_sys);
    #1;
    tbl_rd_addr = '{pos[7], pos[6:1]};
    tbl_rd_en = 1'b1;
    @(posedge clk_sys);
    #1;
    vld = tbl_rd_valid;
    b = pos[0] ? tbl_rd_data[15:8] : tbl_rd_data[7:0];
    tbl_rd_en = 1'b0;
    tbl_rd_addr = ~tbl_rd_addr;
  endtask
endmodule
`default_nettype wire

// file: lpteb_pkg.sv
package lpteb_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int LINK_MAX = 16;
  localparam int TABLE_BYTES = 256;
  localparam int TABLE_ROWS = 128;
  localparam int BANK_ROWS = 64;

  // ------------------------------------------------------------
  // Input word layout and parameter address map
  // ------------------------------------------------------------
  localparam logic [7:0] PARAM_MSG_TYPE = 8'hA5;
  localparam logic [1:0] ERR_REGION = 2'h1;
  localparam logic [3:0] DEST_REGION = 4'h2;
  localparam logic [1:0] FLD_THR_LO = 2'h0;
  localparam logic [1:0] FLD_THR_HI = 2'h1;
  localparam logic [1:0] FLD_INC_LO = 2'h2;
  localparam logic [1:0] FLD_INC_HI = 2'h3;

  // ------------------------------------------------------------
  // Reset values and count limits
  // ------------------------------------------------------------
  localparam logic [15:0] THR_RESET = 16'h00FF;
  localparam logic [15:0] INC_RESET = 16'h0001;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_STEP = 16'h0001;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] msg_type;
    logic [7:0] addr;
    logic [7:0] value;
  } lpteb_param_type;

  typedef struct packed {
    logic bank;
    logic [5:0] row;
  } lpteb_row_type;

  typedef struct packed {
    logic [3:0] link;
    logic [7:0] dest;
  } lpteb_recfg_type;

endpackage

// file: lpteb_properties.sv
`timescale 1ns/10ps
`default_nettype none
module lpteb_checker
  import lpteb_pkg::*;
#(
  parameter int N_LINKS = LINK_MAX
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic param_valid,
  input wire lpteb_param_type param_word,
  input wire logic recfg_valid,
  input wire lpteb_recfg_type recfg,
  input wire logic [N_LINKS-1:0] link_error,
  input wire logic [N_LINKS-1:0] link_tx_ok,
  input wire logic tbl_rd_en,
  input wire lpteb_row_type tbl_rd_addr,
  input wire logic [15:0] tbl_rd_data,
  input wire logic tbl_rd_valid,
  input wire logic [N_LINKS-1:0] err_report,
  input wire logic [N_LINKS-1:0] err_over,
  input wire logic [N_LINKS-1:0][15:0] err_count
);
  // Link 0 stands for all links in the assertions to keep the checker small; the ceiling cover watches link 1
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire logic e0 = link_error[0] && !link_tx_ok[0];
  wire logic o0 = link_tx_ok[0] && !link_error[0];
  a_read_valid_lat: assert property (tbl_rd_en |=> tbl_rd_valid)
    else $error("read answer missing");
  a_read_valid_one: assert property (!tbl_rd_en |=> !tbl_rd_valid)
    else $error("read answer unasked");
  a_count_up: assert property (e0
    |=> err_count[0] >= $past(err_count[0]))
    else $error("count fell on error");
  a_count_down: assert property (o0 && err_count[0] != 16'h0
    |=> err_count[0] == $past(err_count[0]) - 16'h1)
    else $error("count not lowered by one");
  a_count_hold: assert property (!link_error[0] && !link_tx_ok[0]
    |=> $stable(err_count[0]))
    else $error("count moved idle");
  a_floor_zero: assert property (o0 && err_count[0] == 16'h0
    |=> err_count[0] == 16'h0)
    else $error("count wrapped below zero");
  a_ceil_no_wrap: assert property (e0 && err_count[0] == 16'hFFFF
    |=> err_count[0] == 16'hFFFF)
    else $error("count wrapped above max");
  a_report_edge: assert property (err_report[0] == $rose(err_over[0]))
    else $error("report not on reaching threshold");
  c_report: cover property (err_report[0]);
  c_read: cover property (tbl_rd_valid);
  c_ceil: cover property (err_count[1] == 16'hFFFF);
  c_clash: cover property (param_valid && recfg_valid);
endmodule
bind lpteb_top lpteb_checker #(.N_LINKS(N_LINKS)) u_chk (.*);
`default_nettype wire

// file: lpteb_table_mem.sv
`timescale 1ns/10ps
`default_nettype none

module lpteb_table_mem #(
  parameter int ROWS = 128
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_byte,
  input wire logic rd_en,
  input wire logic [6:0] rd_row,
  output logic [15:0] rd_data
);

  // ------------------------------------------------------------
  // Storage: even bytes in the low half of a row
  // ------------------------------------------------------------
  logic [7:0] mem_lo [ROWS];
  logic [7:0] mem_hi [ROWS];
  logic [15:0] rd_data_q;

  // No reset on the array: contents are only valid once written
  always_ff @(posedge clk_sys) begin
    if (wr_en && !wr_addr[0]) begin
      mem_lo[wr_addr[7:1]] <= wr_byte;
    end
    if (wr_en && wr_addr[0]) begin
      mem_hi[wr_addr[7:1]] <= wr_byte;
    end
    if (rd_en) begin
      rd_data_q <= {mem_hi[rd_row], mem_lo[rd_row]};
    end
  end

  assign rd_data = rd_data_q;

endmodule

`default_nettype wire

// file: lpteb_top.sv
// Notes on behaviour
// [R1] Keep a count per link; report once the count reaches its threshold.
// [R2] On a link error, add that link's increment to its count.
// [R3] On each successful transmission, lower that link's count by one.
// [R4] Threshold and increment are 16 bits, each byte written separately.
// [R5] Parameter table fills answer memory banks 6 and 7, host readable.
// [R6] Table byte position equals bits 15..8 of the parameter word.
// [R7] Row is byte position shifted right; rows above 63 are bank 7.
// [R8] Each entry holds the parameter byte exactly as last written; positions 8'h20..8'h2F here also take derived destination bytes.
// [R9] Derived values, like reconfigured destination numbers, enter the table.
// [R10] A parameter word carries type, address and one value byte.
// [R11] The count saturates at zero and at 16'hFFFF, never wrapping.
`timescale 1ns/10ps
`default_nettype none

module lpteb_top
  import lpteb_pkg::*;
#(
  parameter int N_LINKS = LINK_MAX
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic param_valid,
  input wire lpteb_param_type param_word,
  input wire logic recfg_valid,
  input wire lpteb_recfg_type recfg,
  input wire logic [N_LINKS-1:0] link_error,
  input wire logic [N_LINKS-1:0] link_tx_ok,
  input wire logic tbl_rd_en,
  input wire lpteb_row_type tbl_rd_addr,
  output logic [15:0] tbl_rd_data,
  output logic tbl_rd_valid,
  output logic [N_LINKS-1:0] err_report,
  output logic [N_LINKS-1:0] err_over,
  output logic [N_LINKS-1:0][15:0] err_count
);

  // ------------------------------------------------------------
  // Parameter word decode
  // ------------------------------------------------------------
  wire param_hit;
  wire err_sel;
  wire [3:0] err_link;
  wire [1:0] err_fld;
  wire [7:0] param_pos;

  // Words of another message type are not parameters and are ignored
  assign param_hit = param_valid &&
                     (param_word.msg_type == PARAM_MSG_TYPE); // [R10]
  assign param_pos = param_word.addr; // [R6]
  assign err_sel = param_hit && (param_pos[7:6] == ERR_REGION);
  assign err_link = param_pos[5:2];
  assign err_fld = param_pos[1:0];

  // ------------------------------------------------------------
  // Derived values: reconfiguration destinations
  // ------------------------------------------------------------
  logic recfg_pend_q;
  logic recfg_pend_d;
  lpteb_recfg_type recfg_hold_q;
  lpteb_recfg_type recfg_hold_d;
  wire recfg_wr;
  wire [7:0] recfg_pos;
  lpteb_recfg_type recfg_src;

  // A parameter write owns the table port; a clashing derived write
  // waits for the next slot without one, and a newer one arriving while it waits supersedes it
  assign recfg_src = recfg_pend_q ? recfg_hold_q : recfg;
  assign recfg_wr = !param_hit && (recfg_pend_q || recfg_valid);
  assign recfg_pos = {DEST_REGION, recfg_src.link}; // [R9]

  always_comb begin
    recfg_pend_d = recfg_pend_q;
    recfg_hold_d = recfg_hold_q;
    if (recfg_wr) begin
      recfg_pend_d = recfg_pend_q && recfg_valid;
      recfg_hold_d = recfg;
    end else if (recfg_valid) begin
      recfg_pend_d = 1'b1;
      recfg_hold_d = recfg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      recfg_pend_q <= 1'b0;
      recfg_hold_q <= '0;
    end else begin
      recfg_pend_q <= recfg_pend_d;
      recfg_hold_q <= recfg_hold_d;
    end
  end

  // ------------------------------------------------------------
  // Parameter table
  // ------------------------------------------------------------
  wire tbl_wr_en;
  wire [7:0] tbl_wr_addr;
  wire [7:0] tbl_wr_byte;
  wire [6:0] tbl_rd_row;
  logic tbl_rd_valid_q;

  assign tbl_wr_en = param_hit || recfg_wr;
  // Byte goes in untouched, at its own address in banks 6 and 7
  assign tbl_wr_addr = param_hit ? param_pos : recfg_pos; // [R5] [R6]
  assign tbl_wr_byte = param_hit ? param_word.value : recfg_src.dest; // [R8]
  // Bank bit on top: rows 64..127 of the whole table are bank 7
  assign tbl_rd_row = {tbl_rd_addr.bank, tbl_rd_addr.row}; // [R7]

  lpteb_table_mem #(
    .ROWS(TABLE_ROWS)
  ) u_table (
    .clk_sys(clk_sys),
    .wr_en(tbl_wr_en),
    .wr_addr(tbl_wr_addr),
    .wr_byte(tbl_wr_byte),
    .rd_en(tbl_rd_en),
    .rd_row(tbl_rd_row),
    .rd_data(tbl_rd_data)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tbl_rd_valid_q <= 1'b0;
    end else begin
      tbl_rd_valid_q <= tbl_rd_en;
    end
  end

  assign tbl_rd_valid = tbl_rd_valid_q;

  // ------------------------------------------------------------
  // Leaky bucket per link
  // ------------------------------------------------------------
  for (genvar i = 0; i < N_LINKS; i++) begin : g_link
    logic [15:0] thr_q;
    logic [15:0] thr_d;
    logic [15:0] inc_q;
    logic [15:0] inc_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic over_q;
    logic report_q;
    wire me;
    wire [16:0] sum;
    wire [15:0] up;
    wire over_d;
    wire thr_lo_wr;
    wire thr_hi_wr;
    wire inc_lo_wr;
    wire inc_hi_wr;
    wire dec;

    assign me = err_sel && (err_link == 4'(i));
    assign thr_lo_wr = me && (err_fld == FLD_THR_LO);
    assign thr_hi_wr = me && (err_fld == FLD_THR_HI);
    assign inc_lo_wr = me && (err_fld == FLD_INC_LO);
    assign inc_hi_wr = me && (err_fld == FLD_INC_HI);

    // Each byte has its own address; the other byte is kept
    always_comb begin
      thr_d = thr_q;
      inc_d = inc_q;
      if (thr_lo_wr) begin
        thr_d[7:0] = param_word.value; // [R4]
      end
      if (thr_hi_wr) begin
        thr_d[15:8] = param_word.value; // [R4]
      end
      if (inc_lo_wr) begin
        inc_d[7:0] = param_word.value; // [R4]
      end
      if (inc_hi_wr) begin
        inc_d[15:8] = param_word.value; // [R4]
      end
    end

    // Error and success in one cycle: add first, then take one step
    assign sum = {1'b0, cnt_q} + {1'b0, inc_q}; // [R2]
    assign up = !link_error[i] ? cnt_q :
                (sum[16] ? CNT_MAX : sum[15:0]); // [R11]
    // Floor test follows the add, so an error at zero is not lost
    assign dec = link_tx_ok[i] && (up != CNT_RESET); // [R3] [R11]

    always_comb begin
      cnt_d = up;
      if (dec) begin
        cnt_d = up - CNT_STEP; // [R3] [R11]
      end
    end

    // Threshold of zero is excluded by its own test, so it disables reports
    assign over_d = (thr_q != CNT_RESET) && (cnt_d >= thr_q); // [R1]

    always_ff @(posedge clk_sys) begin
      if (reset) begin
        thr_q <= THR_RESET;
        inc_q <= INC_RESET;
        cnt_q <= CNT_RESET;
        over_q <= 1'b0;
        report_q <= 1'b0;
      end else begin
        thr_q <= thr_d;
        inc_q <= inc_d;
        cnt_q <= cnt_d;
        over_q <= over_d;
        report_q <= over_d && !over_q; // [R1]
      end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign err_count[i] = cnt_q;
    assign err_over[i] = over_q;
    assign err_report[i] = report_q;
  end

endmodule

`default_nettype wire

// file: lpteb_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lpteb_top_tb
  import lpteb_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [15:0] link_error = '0;
  logic [15:0] link_tx_ok = '0;
  logic param_valid, recfg_valid, tbl_rd_en, tbl_rd_valid, vld, ov;
  lpteb_param_type param_word;
  lpteb_recfg_type recfg;
  lpteb_row_type tbl_rd_addr;
  logic [15:0] tbl_rd_data, err_report, err_over;
  logic [15:0][15:0] err_count;
  logic [15:0] cnt [16], thr [16], inc [16];
  logic ovr [16];
  logic [7:0] a, v, b;
  logic [31:0] s = 32'h6;
  int fails = 0;
  int n_compared = 0;
  lpteb_top u_dut (.*);
  lpteb_host_model u_host (.*);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[15:0];
  endfunction
  // Add saturates first, then one step down, floor at zero
  function automatic logic [15:0] nxt(input logic [15:0] c, i,
                                      input logic e, o);
    logic [16:0] t;
    t = e ? {1'b0, c} + i : {1'b0, c};
    if (t > 17'h0FFFF) t = 17'h0FFFF;
    if (o && t != 17'h0) t = t - 17'h1;
    return t[15:0];
  endfunction
  task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    chk_val({15'h0, g}, {15'h0, e});
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] vl);
    u_host.put(PARAM_MSG_TYPE, ad, vl);
    if (ad[7:6] == ERR_REGION) begin
      case (ad[1:0])
        FLD_THR_LO: thr[ad[5:2]][7:0] = vl;
        FLD_THR_HI: thr[ad[5:2]][15:8] = vl;
        FLD_INC_LO: inc[ad[5:2]][7:0] = vl;
        default: inc[ad[5:2]][15:8] = vl;
      endcase
    end
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    u_host.get(ad, b, vld);
    chk_flag(vld, 1'b1);
    chk_val({8'h00, b}, {8'h00, e});
  endtask
  task automatic test_done();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 16; i++) begin
      {cnt[i], thr[i], inc[i], ovr[i]} =
        {CNT_RESET, THR_RESET, INC_RESET, 1'b0};
    end
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    // Bank edges first, then random positions
    for (int k = 0; k < 12; k++) begin
      a = (k < 4) ? {k[1], {7{k[0]}}} : 8'(xs());
      v = 8'(xs());
      wr(a, v);
      rd(a, v);
    end
    u_host.put(~PARAM_MSG_TYPE, a, ~v);
    rd(a, v);
    v = 8'(xs());
    u_host.cfg(4'h3, v);
    rd(8'h23, v);
    // Parameter and derived write in one cycle: derived lands a slot later
    fork
      wr(8'h10, 8'h5A);
      u_host.cfg(4'h7, 8'hC3);
    join
    rd(8'h10, 8'h5A);
    rd(8'h27, 8'hC3);
    // Link 0 threshold 3 step 2; link 1 step 16'hFFFF to hit the ceiling
    wr(8'h40, 8'h03);
    wr(8'h41, 8'h00);
    wr(8'h42, 8'h02);
    wr(8'h43, 8'h00);
    wr(8'h46, 8'hFF);
    wr(8'h47, 8'hFF);
    for (int t = 0; t < 1200; t++) begin
      link_error = t[7] ? xs() & xs() & xs() : xs();
      link_tx_ok = t[7] ? xs() : xs() & xs() & xs();
      @(posedge clk_sys);
      #1;
      for (int i = 0; i < 16; i++) begin
        cnt[i] = nxt(cnt[i], inc[i], link_error[i], link_tx_ok[i]);
        ov = thr[i] != 16'h0 && cnt[i] >= thr[i];
        chk_val(err_count[i], cnt[i]);
        chk_flag(err_over[i], ov);
        chk_flag(err_report[i], ov && !ovr[i]);
        ovr[i] = ov;
      end
    end
    test_done();
  end
endmodule
`default_nettype wire
